//--- hw/sram_ctrl_pkg.sv
// Overview of operation
// - Low six bits row, high six column
// - Hold inputs 100 ns after fall
// - Direction high write, low read
// - Write data settled before fall
// - Address settled before select falls
// - Read strobe low 215 ns to 1 ms
// - Write strobe low 215 ns to 1 ms
// - Strobe falls at least 400 ns apart
package sram_ctrl_pkg;
	localparam int ADDR_W             = 12;   // Word address width
	localparam int ROW_W              = 6;    // Low address half
	localparam int CLK_PERIOD_NS      = 8;    // sys_clk period
	localparam int ACCESS_DELAY_NS    = 215;  // Output valid after fall
	localparam int STROBE_WIDTH_NS    = 215;  // Least strobe low time
	localparam int INPUT_HOLD_TIME_NS = 100;  // Inputs held after fall
	localparam int INPUT_SETUP_TIME_NS = 0;   // Inputs before fall
	localparam int CYCLE_PERIOD_NS    = 400;  // Fall to fall
	localparam int STROBE_MAX_NS      = 1000000; // Longest strobe, 1 ms
	// Least times round up to whole cycles; setup is at least one
	localparam int STROBE_CYC =
		(STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC =
		(ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC =
		(INPUT_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC_RAW =
		(INPUT_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
	localparam int CYCLE_CYC =
		(CYCLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_MAX_CYC = STROBE_MAX_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 8;                 // Phase counter width
	localparam logic DIR_WRITE = 1'b1;        // Direction pin for write
	localparam logic DIR_READ  = 1'b0;        // Direction pin for read
	typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_RECOVER} state_t;
endpackage

//--- hw/cycle_timer.sv
`timescale 1ns/1ns
// Down counter; load starts it, done pulses the cycle after it reaches one
module cycle_timer #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              done
);
	logic [W-1:0] count;       // Cycles left
	logic [W-1:0] next_count;
	logic         next_done;

	// Next count and expiry
	always_comb begin
		next_count = count;
		next_done  = 1'b0;
		if (load) begin
			next_count = load_val;
		end else if (count != '0) begin
			next_count = count - 1'b1;
			next_done  = (count == {{(W-1){1'b0}}, 1'b1});
		end
	end

	// Register state
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
			done  <= 1'b0;
		end else begin
			count <= next_count;
			done  <= next_done;
		end
	end
endmodule // cycle_timer

//--- hw/sram_strobe_ctrl.sv
`timescale 1ns/1ns
// Drives a 4096x1 edge-strobed static memory from a simple request port
module sram_strobe_ctrl #(
	// Phase lengths in clock cycles; defaults follow the package
	// and must be worked out again if the clock changes
	parameter int STROBE_CYC = sram_ctrl_pkg::STROBE_CYC,
	parameter int CYCLE_CYC  = sram_ctrl_pkg::CYCLE_CYC,
	parameter int HOLD_CYC   = sram_ctrl_pkg::HOLD_CYC,
	parameter int SETUP_CYC  = sram_ctrl_pkg::SETUP_CYC
) (
	// Single clock; every phase is a count of its cycles
	input  wire logic                              sys_clk,
	// Asynchronous reset, active low
	input  wire logic                              nrst,
	// User side: one request at a time, taken when ready is high
	// Read result comes back as a one-cycle valid with a held bit
	input  wire logic                              req_valid,
	input  wire logic                              req_write,
	input  wire logic [sram_ctrl_pkg::ADDR_W-1:0]  req_addr,
	input  wire logic                              req_wdata,
	output logic                                   req_ready,
	output logic                                   rd_valid,
	output logic                                   rd_data,
	// Memory pins, all registered so the strobe edge is clean
	// The data pin from the memory is sampled in reads only
	output logic [sram_ctrl_pkg::ADDR_W-1:0]       mem_addr,
	output logic                                   mem_dir,
	output logic                                   mem_din,
	output logic                                   mem_sel_n,
	input  wire logic                              mem_dout_n
);
	// Width of the phase counters; must hold the fall-to-fall count
	// at this clock, so a faster clock needs a wider counter
	localparam int W = sram_ctrl_pkg::CNT_W;

	// Sequencer state and its next value
	sram_ctrl_pkg::state_t state;       // Access sequencer
	sram_ctrl_pkg::state_t next_state;
	// Strobe low time counter
	logic [W-1:0] low_cnt;              // Cycles since strobe fell
	logic [W-1:0] next_low_cnt;
	// Spacing between strobe falls, kept apart from the sequencer
	// so a quick request still waits for the memory to recover
	logic         timer_load;           // Starts fall-to-fall timer
	logic         gap_done;             // Cycle period elapsed
	logic         gap_busy;             // Spacing still running
	logic         next_gap_busy;
	// Direction of the access in progress, kept for the read sample
	logic         write_cyc;            // Latched direction of cycle
	logic         next_write_cyc;
	// Next values of the registered outputs
	logic         next_req_ready;
	logic         next_rd_valid;
	logic         next_rd_data;
	// Next values of the memory pins
	logic [sram_ctrl_pkg::ADDR_W-1:0] next_mem_addr;
	logic         next_mem_dir;
	logic         next_mem_din;
	logic         next_mem_sel_n;
	// Setup phase length before the strobe may fall
	// Zero setup time still leaves one cycle of settled pins
	logic [W-1:0] setup_left;           // Setup cycles left
	logic [W-1:0] next_setup_left;

	// Saturating compare helper, used for several phase checks
	// The count is widened to int so a limit above the counter
	// range never wraps into a false match
	function automatic logic reached(input logic [W-1:0] c,
		input int lim);
		reached = (int'(c) >= lim);
	endfunction

	// Fall-to-fall spacing timer
	// Loaded at each strobe fall; its done pulse frees the next fall.
	// The pulse comes a cycle after the count reaches one, so the
	// spacing is one cycle longer than the least, traded for a
	// registered done with no path back into the load logic
	cycle_timer #(.W(W)) u_gap (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.load     (timer_load),
		.load_val (W'(CYCLE_CYC)),
		.done     (gap_done)
	);

	// Sequencer next values
	// Every next value but ready defaults to its present value, so a branch
	// only names what it changes; pulses default low
	always_comb begin
		next_state      = state;
		next_low_cnt    = low_cnt;
		next_write_cyc  = write_cyc;
		// Valid is a one-cycle pulse; the read bit holds till the next
		next_rd_valid   = 1'b0;
		next_rd_data    = rd_data;
		next_mem_addr   = mem_addr;
		next_mem_dir    = mem_dir;
		next_mem_din    = mem_din;
		next_mem_sel_n  = mem_sel_n;
		next_setup_left = setup_left;
		next_gap_busy   = gap_busy;
		// Ready is raised only by idle and recovery
		next_req_ready  = 1'b0;
		// Timer load is a one-cycle pulse at the fall
		timer_load      = 1'b0;
		// Spacing ends; a fall in this cycle sets it again below
		if (gap_done) begin
			next_gap_busy = 1'b0;
		end
		// One branch per phase of the access
		case (state)
			// Waiting for work with ready shown
			sram_ctrl_pkg::ST_IDLE: begin
				next_req_ready = 1'b1;
				// Request taken only while ready is shown
				if (req_valid && req_ready) begin
					next_req_ready  = 1'b0;
					// Pins settled before strobe falls
					next_mem_addr   = req_addr;
					next_mem_dir    = req_write ? sram_ctrl_pkg::DIR_WRITE
						: sram_ctrl_pkg::DIR_READ;
					// Data pin parked low in reads; the memory ignores it
					next_mem_din    = req_write ? req_wdata : 1'b0;
					// Direction kept for the end of the cycle
					next_write_cyc  = req_write;
					// Setup counted from the cycle the pins change
					next_setup_left = W'(SETUP_CYC);
					// Setup phase next
					next_state      = sram_ctrl_pkg::ST_SETUP;
				end
			end
			// Pins settled; strobe falls when setup and spacing are met
			sram_ctrl_pkg::ST_SETUP: begin
				// Also waits out the previous fall-to-fall spacing
				// Extra setup cycles, none at the default setting
				if (setup_left > W'(1)) begin
					next_setup_left = setup_left - 1'b1;
				end else if (!next_gap_busy) begin
					// Strobe falls and the spacing timer starts together
					next_mem_sel_n = 1'b0;
					timer_load     = 1'b1;
					next_gap_busy  = 1'b1;
					// Low time counted from the fall
					next_low_cnt   = '0;
					next_state     = sram_ctrl_pkg::ST_LOW;
				end
			end
			// Strobe low; counts up to the least width and hold time
			sram_ctrl_pkg::ST_LOW: begin
				// Pins stay untouched here, covering hold time
				next_low_cnt = low_cnt + 1'b1;
				// Strobe lasts the least width, far below 1 ms; the read
				// sample also waits out the access delay, so a shorter
				// strobe setting cannot sample a line still settling
				if (reached(low_cnt + 1'b1, STROBE_CYC)
					&& reached(low_cnt + 1'b1, HOLD_CYC)
					&& reached(low_cnt + 1'b1,
					sram_ctrl_pkg::ACCESS_CYC)) begin
					// Strobe rises; pins stay put through recovery
					next_mem_sel_n = 1'b1;
					// One recovery cycle follows every access
					next_state     = sram_ctrl_pkg::ST_RECOVER;
					// Writes leave the output unread
					if (!write_cyc) begin
						// Output is driven and valid by now
						next_rd_valid = 1'b1;
						// Pin carries the inverse of the stored bit
						next_rd_data  = ~mem_dout_n;
					end
				end
			end
			// Strobe back high; pins still hold the last access
			sram_ctrl_pkg::ST_RECOVER: begin
				// One cycle high before accepting more work
				// Ready returns now; the next fall still waits for spacing
				next_state     = sram_ctrl_pkg::ST_IDLE;
				next_req_ready = 1'b1;
			end
			// Unreachable codes return to idle
			default: begin
				next_state     = sram_ctrl_pkg::ST_IDLE;
				// Strobe forced high so the memory is left idle
				next_mem_sel_n = 1'b1;
			end
		endcase
	end

	// Register sequencer and pins
	// Reset parks the strobe high so the memory stays deselected
	// and its output floats until the first request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			// Constants only in the reset branch
			state      <= sram_ctrl_pkg::ST_IDLE;
			low_cnt    <= '0;
			write_cyc  <= 1'b0;
			req_ready  <= 1'b0;
			rd_valid   <= 1'b0;
			rd_data    <= 1'b0;
			mem_addr   <= '0;
			mem_dir    <= sram_ctrl_pkg::DIR_READ;
			mem_din    <= 1'b0;
			// Deselected: memory idle, output line free
			mem_sel_n  <= 1'b1;
			setup_left <= '0;
			gap_busy   <= 1'b0;
		end else begin
			// Plain register stage; all decisions are made above
			state      <= next_state;
			low_cnt    <= next_low_cnt;
			write_cyc  <= next_write_cyc;
			req_ready  <= next_req_ready;
			rd_valid   <= next_rd_valid;
			rd_data    <= next_rd_data;
			mem_addr   <= next_mem_addr;
			mem_dir    <= next_mem_dir;
			mem_din    <= next_mem_din;
			mem_sel_n  <= next_mem_sel_n;
			setup_left <= next_setup_left;
			gap_busy   <= next_gap_busy;
		end
	end
endmodule // sram_strobe_ctrl

//--- verif/sram_strobe_chk.sv
`timescale 1ns/1ns
// Pin timing watcher for the strobe controller
module sram_strobe_chk #(
	parameter int STROBE_CYC = sram_ctrl_pkg::STROBE_CYC,
	parameter int CYCLE_CYC  = sram_ctrl_pkg::CYCLE_CYC
) (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        req_valid,
	input wire logic        req_write,
	input wire logic [11:0] req_addr,
	input wire logic        req_wdata,
	input wire logic        req_ready,
	input wire logic        rd_valid,
	input wire logic [11:0] mem_addr,
	input wire logic        mem_dir,
	input wire logic        mem_din,
	input wire logic        mem_sel_n
);
	localparam int FALL_MAX = 60; // Take to fall, spacing wait included
	int low_cnt;                  // Cycles the strobe has been low
	int gap;                      // Cycles since the last fall
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Counters; gap starts full so the first fall is legal
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			low_cnt <= 0;
			gap <= CYCLE_CYC;
		end else begin
			low_cnt <= mem_sel_n ? 0 : low_cnt + 1;
			gap <= $fell(mem_sel_n) ? 1 : gap + 1;
		end
	end
	chk_setup_stable: assert property (
		$fell(mem_sel_n) |-> $stable({mem_addr, mem_dir, mem_din}))
		else $error("pins moved at strobe fall");
	chk_hold_stable: assert property (
		!mem_sel_n && !$fell(mem_sel_n) |-> $stable({mem_addr, mem_din}))
		else $error("pins moved while strobe low");
	chk_strobe_width: assert property (
		$rose(mem_sel_n) |-> low_cnt == STROBE_CYC)
		else $error("strobe low time wrong");
	chk_fall_spacing: assert property (
		$fell(mem_sel_n) |-> gap >= CYCLE_CYC)
		else $error("strobe falls too close");
	chk_pins_follow: assert property (
		req_valid && req_ready |=> mem_addr == $past(req_addr)
		&& mem_dir == $past(req_write)
		&& mem_din == ($past(req_wdata) & $past(req_write)))
		else $error("pins differ from request");
	chk_take_strobe: assert property (
		req_valid && req_ready |-> ##[1:FALL_MAX] $fell(mem_sel_n))
		else $error("no strobe after request");
	chk_busy_refuse: assert property (
		!mem_sel_n |-> !req_ready)
		else $error("ready during strobe");
	chk_read_only: assert property (
		rd_valid |-> $rose(mem_sel_n) && mem_dir == sram_ctrl_pkg::DIR_READ)
		else $error("read data outside read end");
endmodule // sram_strobe_chk

//--- verif/sram_model.sv
`timescale 1ns/1ns
// Behavioural 4096x1 memory on the far side of the pins
module sram_model (
	input  wire logic        sys_clk,
	input  wire logic [11:0] mem_addr,
	input  wire logic        mem_dir,
	input  wire logic        mem_din,
	input  wire logic        mem_sel_n,
	output logic             mem_dout_n
);
	logic cells [64][64]; // Column by row
	logic held;           // Bit read at the fall
	logic shown = 1'b0;   // Output stage live
	logic junk = 1'b0;    // Level of the undriven line
	// Latch at the fall, data only after the access delay
	always @(negedge mem_sel_n) begin
		shown = 1'b0;
		held = cells[mem_addr[11:6]][mem_addr[5:0]];
		if (mem_dir)
			cells[mem_addr[11:6]][mem_addr[5:0]] = mem_din;
		#(sram_ctrl_pkg::ACCESS_DELAY_NS);
		shown = !mem_sel_n;
	end
	always @(posedge mem_sel_n) shown = 1'b0;
	// No pull-up: a clock after the fall the undriven line settles to the
	// wrong bit, so a sample from then until the access delay reads false
	always @(posedge sys_clk) junk <= held;
	assign mem_dout_n = shown ? ~held : junk;
endmodule // sram_model

//--- verif/testbench.sv
`timescale 1ns/1ns
// Random and corner accesses through the strobe controller
module testbench;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [11:0] req_addr = 12'h000;
	logic        req_wdata = 1'b0;
	logic        req_ready, rd_valid, rd_data, mem_dir, mem_din;
	logic        mem_sel_n, mem_dout_n;
	logic [11:0] mem_addr;
	logic        shadow [4096]; // Expected cells
	logic [11:0] addrs [24];    // Addresses under test
	logic [11:0] corner [6] = '{12'h000, 12'h03F, 12'h040, 12'hFC0,
		12'hFFF, 12'h7FF};
	int          num_errors = 0;
	int          total_checks = 0;
	int          seed = 32'hca7b;
	always #4 sys_clk = ~sys_clk;
	sram_strobe_ctrl u_sram_strobe_ctrl (.sys_clk(sys_clk), .nrst(nrst),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .mem_addr(mem_addr), .mem_dir(mem_dir),
		.mem_din(mem_din), .mem_sel_n(mem_sel_n), .mem_dout_n(mem_dout_n));
	sram_model u_sram_model (.sys_clk(sys_clk), .mem_addr(mem_addr),
		.mem_dir(mem_dir), .mem_din(mem_din), .mem_sel_n(mem_sel_n),
		.mem_dout_n(mem_dout_n));
	function automatic logic exp_bit(input logic [11:0] a);
		return shadow[a];
	endfunction
	task automatic check(input string what, input logic e, input logic s);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %b seen %b", what, e, s);
		end
	endtask
	// One access; entered and left just after a rising edge
	task automatic op(input logic w, input logic [11:0] a, input logic d);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		do @(negedge sys_clk); while (req_ready !== 1'b1 && ++n < 200);
		check("req_ready", 1'b1, req_ready);
		@(posedge sys_clk);
		req_valid <= 1'b0;
		if (w)
			shadow[a] = d;
		else begin
			do @(negedge sys_clk); while (rd_valid !== 1'b1 && ++n < 400);
			check("rd_valid", 1'b1, rd_valid);
			check("rd_data", exp_bit(a), rd_data);
		end
		// An edge passes with the request low before the next call
		@(posedge sys_clk);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		foreach (addrs[i]) addrs[i] = i < 6 ? corner[i] : 12'($random(seed));
		foreach (addrs[i]) op(1'b1, addrs[i], 1'($random(seed)));
		foreach (addrs[i]) op(1'b0, addrs[23 - i], 1'b0);
		// Flip each cell and read it straight back
		foreach (addrs[i]) begin
			op(1'b1, addrs[i], ~shadow[addrs[i]]);
			op(1'b0, addrs[i], 1'b0);
		end
		stop_test();
	end
	// Hang guard, well past the expected run
	initial begin
		#200000;
		num_errors++;
		stop_test();
	end
endmodule // testbench
bind sram_strobe_ctrl sram_strobe_chk #(.STROBE_CYC(STROBE_CYC),
	.CYCLE_CYC(CYCLE_CYC)) u_sram_strobe_chk (.sys_clk(sys_clk),
	.nrst(nrst), .req_valid(req_valid), .req_write(req_write),
	.req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
	.rd_valid(rd_valid), .mem_addr(mem_addr), .mem_dir(mem_dir),
	.mem_din(mem_din), .mem_sel_n(mem_sel_n));
